/* File: hps_pkg.sv */
package hps_pkg;

    // Host data bus and register file geometry
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 2;
    localparam int REG_DEPTH = 4;
    localparam int CHANNELS  = 2;

    // Data pins that double as serial configuration straps
    localparam int CPOL_BIT = 7;
    localparam int CPHA_BIT = 6;
    localparam int SWAP_BIT = 5;

    // Interface mode select levels
    localparam logic MODE_PARALLEL = 1'b0;
    localparam logic MODE_SERIAL   = 1'b1;

    // Bit order codes on the swap pin
    localparam logic ORDER_MSB_FIRST = 1'b0;
    localparam logic ORDER_LSB_FIRST = 1'b1;

    // Serial control word: flag bits that never move with the bit order
    localparam int CTRL_RW_POS   = 0;
    localparam int CTRL_FLAG_POS = 1;

    // Values after reset
    localparam logic              CFG_RESET  = 1'b0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // Host pins sampled together
    typedef struct packed {
        logic              cs1_n;
        logic              cs2_n;
        logic              rd_n;
        logic              wr_n;
        logic              mode;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hps_pins_s;

    // Idle pins: strobes and selects inactive, parallel mode
    localparam hps_pins_s PINS_IDLE = '{cs1_n: 1'b1, cs2_n: 1'b1,
                                        rd_n: 1'b1, wr_n: 1'b1,
                                        mode: 1'b0, addr: 2'h0,
                                        data: 8'h00};

endpackage : hps_pkg

/* File: hps_host_port.sv */
`timescale 1ns/1ps

module hps_host_port
    import hps_pkg::*;
(
    input  wire logic              clock_in,                   // 40 MHz
    input  wire logic              nrst_in,                    // Sync reset
    input  wire logic [DATA_W-1:0] data_pin_in,                // Data pins
    output logic      [DATA_W-1:0] data_pin_out,               // Read data
    output logic                   data_pin_oe_out,            // Drive enable
    input  wire logic              channel_one_select_n_in,    // Select ch 1
    input  wire logic              channel_two_select_n_in,    // Select ch 2
    input  wire logic              read_strobe_n_in,           // Read strobe
    input  wire logic              write_strobe_n_in,          // Write strobe
    input  wire logic              serial_mode_sel_in,         // Mode select
    input  wire logic [ADDR_W-1:0] reg_addr_in,                // Register addr
    output logic                   serial_clock_polarity_pin_out, // CPOL
    output logic                   serial_clock_phase_pin_out,    // CPHA
    output logic                   lsb_first_out,              // Field order
    output logic                   serial_mode_out,            // Mode seen
    output logic                   write_done_out,             // Write pulse
    output logic      [DATA_W-1:0] ch1_ctrl_out,               // Ch 1 reg 0
    output logic      [DATA_W-1:0] ch2_ctrl_out                // Ch 2 reg 0
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops, then a delayed copy for edges
    hps_pins_s meta_ff, sync_ff, prev_ff;
    hps_pins_s nxt_meta, nxt_sync, nxt_prev;

    // The first stage feeds only the second
    always_comb begin
        nxt_meta = '{cs1_n: channel_one_select_n_in,
                     cs2_n: channel_two_select_n_in,
                     rd_n:  read_strobe_n_in,
                     wr_n:  write_strobe_n_in,
                     mode:  serial_mode_sel_in,
                     addr:  reg_addr_in,
                     data:  data_pin_in};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            meta_ff <= PINS_IDLE;
            sync_ff <= PINS_IDLE;
            prev_ff <= PINS_IDLE;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel register file, written from the parallel bus
    logic [DATA_W-1:0] regs_ff  [CHANNELS][REG_DEPTH];
    logic [DATA_W-1:0] nxt_regs [CHANNELS][REG_DEPTH];
    logic              wr_rise;
    logic              one_sel_prev;
    logic              nxt_write_done;
    logic              write_done_ff;

    // Only one select may be low; both low is a host fault and is ignored
    assign one_sel_prev = prev_ff.cs1_n ^ prev_ff.cs2_n;

    // Data and address come from the sample taken while the strobe was low,
    // so a host that drops data with the rising edge still lands intact
    assign wr_rise = !prev_ff.wr_n && sync_ff.wr_n && one_sel_prev
                     && (prev_ff.mode == MODE_PARALLEL);

    always_comb begin
        nxt_regs       = regs_ff;
        nxt_write_done = 1'b0;
        if (wr_rise) begin
            // All eight pins, 4 and 3 included, are plain data here
            nxt_regs[prev_ff.cs1_n ? 1 : 0][prev_ff.addr] =
                prev_ff.data;
            nxt_write_done = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            for (int c = 0; c < CHANNELS; c++) begin
                for (int r = 0; r < REG_DEPTH; r++) begin
                    regs_ff[c][r] <= DATA_RESET;
                end
            end
            write_done_ff <= 1'b0;
        end else begin
            regs_ff       <= nxt_regs;
            write_done_ff <= nxt_write_done;
        end
    end

    assign write_done_out = write_done_ff;
    assign ch1_ctrl_out   = regs_ff[0][0];
    assign ch2_ctrl_out   = regs_ff[1][0];

    ////////////////////////////////////////////////////////////////////////
    // Read drive: the bus is driven only for a qualified parallel read
    logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic              oe_ff, nxt_oe;
    logic              one_sel;

    assign one_sel = sync_ff.cs1_n ^ sync_ff.cs2_n;

    // Both selects high leaves one_sel low, so the pins float
    always_comb begin
        nxt_oe      = one_sel && !sync_ff.rd_n
                      && (sync_ff.mode == MODE_PARALLEL);
        nxt_rd_data = DATA_RESET;
        if (nxt_oe) begin
            nxt_rd_data =
                regs_ff[sync_ff.cs1_n ? 1 : 0][sync_ff.addr];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            oe_ff      <= 1'b0;
            rd_data_ff <= DATA_RESET;
        end else begin
            oe_ff      <= nxt_oe;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign data_pin_oe_out = oe_ff;
    assign data_pin_out    = rd_data_ff;

    ////////////////////////////////////////////////////////////////////////
    // Serial configuration straps
    logic cpol_ff, cpha_ff, swap_ff, mode_ff;
    logic nxt_cpol, nxt_cpha, nxt_swap, nxt_mode;
    logic pins_free;

    // Straps are read only while no select is active; during a frame the
    // pins belong to the serial link and a glitch there must not retune it
    assign pins_free = sync_ff.cs1_n && sync_ff.cs2_n;

    always_comb begin
        nxt_mode = sync_ff.mode;
        nxt_cpol = cpol_ff;
        nxt_cpha = cpha_ff;
        nxt_swap = swap_ff;
        if (sync_ff.mode == MODE_PARALLEL) begin
            // Parallel mode: straps return to their defaults
            nxt_cpol = CFG_RESET;
            nxt_cpha = CFG_RESET;
            nxt_swap = ORDER_MSB_FIRST;
        end else if (pins_free) begin
            nxt_cpol = sync_ff.data[CPOL_BIT];
            nxt_cpha = sync_ff.data[CPHA_BIT];
            // Order covers address and data fields only; the RW and flag
            // bits sit at CTRL_RW_POS and CTRL_FLAG_POS for either order
            nxt_swap = sync_ff.data[SWAP_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cpol_ff <= CFG_RESET;
            cpha_ff <= CFG_RESET;
            swap_ff <= ORDER_MSB_FIRST;
            mode_ff <= MODE_PARALLEL;
        end else begin
            cpol_ff <= nxt_cpol;
            cpha_ff <= nxt_cpha;
            swap_ff <= nxt_swap;
            mode_ff <= nxt_mode;
        end
    end

    assign serial_clock_polarity_pin_out = cpol_ff;
    assign serial_clock_phase_pin_out    = cpha_ff;
    assign lsb_first_out                 = swap_ff;
    assign serial_mode_out               = mode_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    sequence s_wr_low_ch1;
        !sync_ff.wr_n && !sync_ff.cs1_n && sync_ff.cs2_n
        && (sync_ff.mode == MODE_PARALLEL);
    endsequence

    sequence s_wr_rise;
        sync_ff.wr_n;
    endsequence

    chk_release_idle: assert property (
        (sync_ff.cs1_n && sync_ff.cs2_n) |=> !data_pin_oe_out)
        else $error("Data pins driven with both selects high");

    chk_read_drive: assert property (
        (!sync_ff.rd_n && !sync_ff.cs1_n && sync_ff.cs2_n
         && (sync_ff.mode == MODE_PARALLEL))
        |=> data_pin_oe_out
            && (data_pin_out == $past(regs_ff[0][sync_ff.addr])))
        else $error("Parallel read did not drive register contents");

    chk_polarity_sample: assert property (
        (sync_ff.mode == MODE_SERIAL && pins_free)
        |=> serial_clock_polarity_pin_out == $past(sync_ff.data[CPOL_BIT]))
        else $error("Polarity strap not sampled");

    chk_phase_sample: assert property (
        (sync_ff.mode == MODE_SERIAL && pins_free)
        |=> serial_clock_phase_pin_out == $past(sync_ff.data[CPHA_BIT]))
        else $error("Phase strap not sampled");

    chk_order_sample: assert property (
        (sync_ff.mode == MODE_SERIAL && pins_free)
        |=> lsb_first_out == $past(sync_ff.data[SWAP_BIT]))
        else $error("Bit order strap not sampled");

    chk_spare_pins_ignored: assert property (
        (sync_ff.mode == MODE_SERIAL && $past(sync_ff.mode == MODE_SERIAL)
         && $stable(sync_ff.data[7:5]) && $changed(sync_ff.data[4:3]))
        |=> $stable(serial_clock_polarity_pin_out)
            && $stable(serial_clock_phase_pin_out) && $stable(lsb_first_out))
        else $error("Pins 4 or 3 changed serial configuration");

    chk_mode_follow: assert property (
        1'b1 |=> serial_mode_out == $past(sync_ff.mode))
        else $error("Serial mode not reflected");

    chk_write_capture: assert property (
        s_wr_low_ch1 ##1 s_wr_rise
        |=> write_done_out
            && (regs_ff[0][$past(sync_ff.addr, 2)] == $past(sync_ff.data, 2)))
        else $error("Write not captured on strobe rise");

endmodule : hps_host_port

/* File: hps_host_model.sv */
`timescale 1ns/1ps
module hps_host_model
    import hps_pkg::*;
(
    input  wire logic              clock_in,  // System clock
    input  wire logic [DATA_W-1:0] bus_in,    // Resolved data pins
    input  wire logic              oe_in,     // Device drives pins
    output hps_pins_s              pins_out,  // Host pins
    output logic                   drive_out  // Host drives data pins
);
    // Quiet bus until the bench asks for an access
    initial begin
        pins_out  = PINS_IDLE;
        drive_out = 1'b0;
    end

    // Strap levels stay static until changed here
    task automatic strap(input logic m, input logic [DATA_W-1:0] d);
        @(posedge clock_in);
        pins_out.mode <= m;
        pins_out.data <= d;
        drive_out     <= 1'b1;
    endtask : strap

    // One access; strobe held for hold edges, read data taken at the last
    task automatic access(input logic ch2, input logic both, input logic wr,
                          input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input int hold,
                          output logic [DATA_W-1:0] q, output logic qoe);
        @(posedge clock_in);
        pins_out.cs1_n <= ch2 & ~both;
        pins_out.cs2_n <= ~ch2 & ~both;
        pins_out.addr  <= a;
        pins_out.data  <= d;
        pins_out.wr_n  <= ~wr;
        pins_out.rd_n  <= wr;
        drive_out      <= wr | pins_out.mode;
        repeat (hold) @(posedge clock_in);
        q   = bus_in;
        qoe = oe_in;
        pins_out.wr_n <= 1'b1;
        pins_out.rd_n <= 1'b1;
        repeat (3) @(posedge clock_in);
        pins_out.cs1_n <= 1'b1;
        pins_out.cs2_n <= 1'b1;
        // Straps keep being driven while serial mode stays selected
        drive_out <= pins_out.mode;
    endtask : access
endmodule : hps_host_model

/* File: hps_host_port_bench.sv */
`timescale 1ns/1ps
module hps_host_port_bench;
    import hps_pkg::*;
    logic        clock_in = 1'b0;
    logic        nrst_in  = 1'b0;
    hps_pins_s   pins;
    logic        hdrv, oe, pol, pha, lsb, smode, wdone, qoe;
    logic [7:0]  dout, bus, c1, c2, q, d;
    logic [7:0]  last_bus = 8'h00;
    int          bad_count = 0;
    int          n_compared = 0;
    int          seed = 85350;
    int          n_done = 0;
    int          exp_done = 0;
    int          ref_mem [8];

    // Clock at 25 ns
    initial forever #12.5 clock_in = ~clock_in;

    // Undriven pins show a changing pattern, not the last value
    assign bus = oe ? dout : (hdrv ? pins.data : ~last_bus);
    always @(posedge clock_in) last_bus <= bus;
    always @(posedge clock_in) if (wdone === 1'b1) n_done++;

    hps_host_model u_host (.clock_in(clock_in), .bus_in(bus), .oe_in(oe),
                           .pins_out(pins), .drive_out(hdrv));
    hps_host_port u_dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .data_pin_in(bus),
        .data_pin_out(dout), .data_pin_oe_out(oe),
        .channel_one_select_n_in(pins.cs1_n),
        .channel_two_select_n_in(pins.cs2_n),
        .read_strobe_n_in(pins.rd_n), .write_strobe_n_in(pins.wr_n),
        .serial_mode_sel_in(pins.mode), .reg_addr_in(pins.addr),
        .serial_clock_polarity_pin_out(pol),
        .serial_clock_phase_pin_out(pha), .lsb_first_out(lsb),
        .serial_mode_out(smode), .write_done_out(wdone),
        .ch1_ctrl_out(c1), .ch2_ctrl_out(c2));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Hang guard, well past the expected run length
    initial begin
        repeat (20000) @(posedge clock_in);
        bad_count++;
        end_of_test();
    end

    // Main sequence: writes, reads, refusals, serial straps
    initial begin
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        check({3'h0, oe, pol, pha, lsb, smode}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            u_host.access(i[2], 1'b0, 1'b1, i[1:0], d, 3, q, qoe);
            ref_mem[i] = d;
            exp_done++;
            repeat (3) @(posedge clock_in);
            check(8'(n_done), 8'(exp_done));
            check(c1, 8'(ref_mem[0]));
            check(c2, 8'(ref_mem[4]));
        end
        for (int i = 7; i >= 0; i--) begin
            u_host.access(i[2], 1'b0, 1'b0, i[1:0], 8'h00, 5, q, qoe);
            check({7'h0, qoe}, 8'h01);
            check(q, 8'(ref_mem[i]));
            repeat (4) @(posedge clock_in);
            check({7'h0, oe}, 8'h00);
        end
        // Both selects low: neither write nor read may take effect
        u_host.access(1'b0, 1'b1, 1'b1, 2'h0, 8'hA5, 3, q, qoe);
        repeat (3) @(posedge clock_in);
        check(8'(n_done), 8'(exp_done));
        check(c1, 8'(ref_mem[0]));
        u_host.access(1'b0, 1'b1, 1'b0, 2'h0, 8'h00, 5, q, qoe);
        check({7'h0, qoe}, 8'h00);
        for (int k = 0; k < 8; k++) begin
            d = {k[2:0], 5'($random(seed))};
            u_host.strap(1'b1, d);
            repeat (4) @(posedge clock_in);
            check({5'h0, pol, pha, lsb}, 8'(k));
            check({7'h0, smode}, 8'h01);
        end
        // Serial mode write is ignored and straps hold through it
        u_host.access(1'b0, 1'b0, 1'b1, 2'h0, d, 3, q, qoe);
        repeat (4) @(posedge clock_in);
        check(8'(n_done), 8'(exp_done));
        check({5'h0, pol, pha, lsb}, 8'h07);
        // Only pins 4 and 3 move: the straps must not follow them
        u_host.strap(1'b1, d ^ 8'h18);
        repeat (4) @(posedge clock_in);
        check({5'h0, pol, pha, lsb}, 8'h07);
        check({7'h0, smode}, 8'h01);
        u_host.strap(1'b0, 8'hE0);
        repeat (4) @(posedge clock_in);
        check({4'h0, pol, pha, lsb, smode}, 8'h00);
        end_of_test();
    end
endmodule : hps_host_port_bench
